// ### core/cpulp_core.sv
// Core register file, operation engine and low-power clock gating
`timescale 1ns/100ps
`default_nettype none

module cpulp_core
   import cpulp_pkg::*;
#(
   parameter bit KEEP_XTAL = 1'b0  // Mask option: crystal never stops
) (
   // Clock and reset
   input  wire  logic        clock_i,
   input  wire  logic        resetn_i,
   // Wishbone slave
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [7:0]  wb_adr_i,
   input  wire  logic [3:0]  wb_sel_i,
   input  wire  logic [31:0] wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   // Peripheral memory bus
   output logic [15:0]       mem_adr_o,
   output logic [15:0]       mem_wdat_o,
   output logic              mem_we_o,
   output logic              mem_re_o,
   input  wire  logic [15:0] mem_rdat_i,
   // Interrupt request and clock controls
   input  wire  logic        irq_i,
   input  wire  logic [15:0] irq_vector_i,
   output logic              aux_clk_en_o,
   output logic              main_clk_en_o,
   output logic              sub_clk_en_o,
   output logic              dco_clk_en_o,
   output logic              dc_gen_en_o,
   output logic              xtal_en_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [15:0]  regs_r [NUM_REGS];
   logic [1:0]   cfg_r;
   cpulp_cmd_t   cmd_r;
   logic [15:0]  operand_r;
   logic         busy_r;
   cpulp_state_t state_r;
   logic         ack_r;
   logic [31:0]  rdat_r;
   logic [15:0]  ptr_r;
   logic [15:0]  save_r;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire         bus_req   = wb_cyc_i & wb_stb_i & ~ack_r;
   wire         bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
   wire         hit_sw    = wb_adr_i == ADR_STATUS;
   wire         hit_cfg   = wb_adr_i == ADR_CLKCFG;
   wire         hit_cmd   = wb_adr_i == ADR_CMD;
   wire         hit_opd   = wb_adr_i == ADR_OPERAND;
   wire         hit_cst   = wb_adr_i == ADR_CLKSTAT;
   wire         hit_reg   = wb_adr_i >= ADR_REGBASE && wb_adr_i <= ADR_REGTOP;
   wire  [3:0]  reg_idx   = wb_adr_i[5:2];
   wire  [15:0] wdat16    = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_dat_i[7:0]};
   wire         start_cmd = bus_wr & hit_cmd & ~busy_r;

   // -----------------------------------------------------------------
   // Status word and clock gating
   // -----------------------------------------------------------------
   wire [15:0] sw        = regs_r[REG_SW] & SW_IMPL_MASK;
   wire        core_off  = sw[SW_CORE_CLOCK_OFF];
   wire        sub_off   = sw[SW_SUBOFF];
   wire        dcg_off   = sw[SW_DCGOFF];
   wire        osc_off   = sw[SW_LOW_FREQ_OSC_OFF];
   wire        main_dco  = ~core_off & ~cfg_r[CFG_MAIN_SRC1];
   wire        sub_dco   = ~sub_off  & ~cfg_r[CFG_SUB_SRC];
   wire        main_xtal = ~core_off &  cfg_r[CFG_MAIN_SRC1];
   wire        sub_xtal  = ~sub_off  &  cfg_r[CFG_SUB_SRC];
   wire        dco_used  = main_dco | sub_dco;
   cpulp_clk_t clk_n;

   // Gate values; the digital osc is held whenever a running clock needs it
   always_comb begin
      clk_n.main_clk_en = ~core_off;
      clk_n.sub_clk_en  = ~sub_off;
      clk_n.dco_clk_en  = dco_used;
      clk_n.dc_gen_en   = ~dcg_off | dco_used;
      clk_n.xtal_en     = ~osc_off | main_xtal | sub_xtal | KEEP_XTAL;
   end

   // Auxiliary clock comes from the crystal and follows it
   assign aux_clk_en_o  = clk_n.xtal_en;
   assign main_clk_en_o = clk_n.main_clk_en;
   assign sub_clk_en_o  = clk_n.sub_clk_en;
   assign dco_clk_en_o  = clk_n.dco_clk_en;
   assign dc_gen_en_o   = clk_n.dc_gen_en;
   assign xtal_en_o     = clk_n.xtal_en;

   // -----------------------------------------------------------------
   // Operand fetch and ALU
   // -----------------------------------------------------------------
   wire [15:0] src_reg  = (cmd_r.src == REG_CG) ? 16'h0000 : regs_r[cmd_r.src];
   wire [15:0] dst_reg  = regs_r[cmd_r.dst];
   wire [15:0] bmask    = cmd_r.byte_op ? 16'h00ff : 16'hffff;
   wire [15:0] step     = cmd_r.byte_op ? BYTE_STEP : WORD_STEP;
   wire        need_mem = cmd_r.smode == SM_IND || cmd_r.smode == SM_INC;
   wire [15:0] src_val  = (cmd_r.smode == SM_IMM) ? operand_r :
                          (cmd_r.smode == SM_REG) ? src_reg   : mem_rdat_i;
   wire [15:0] a        = src_val & bmask;
   wire [15:0] b        = dst_reg & bmask;
   wire        zero_f   = sw[SW_Z];
   logic [16:0] alu;

   // Two-operand result; source combined into destination
   always_comb begin
      unique case (cmd_r.op)
         OP_ADD:  alu = {1'b0, a} + {1'b0, b};
         OP_SUB:  alu = {1'b0, b} - {1'b0, a};
         OP_AND:  alu = {1'b0, a & b};
         OP_XOR:  alu = {1'b0, a ^ b};
         default: alu = {1'b0, a};
      endcase
   end

   wire [15:0] res      = alu[15:0] & bmask;
   wire        res_zero = res == 16'h0000;
   wire        res_neg  = cmd_r.byte_op ? res[7] : res[15];
   wire        res_cry  = cmd_r.byte_op ? alu[8] : alu[16];
   wire        is_dual  = cmd_r.op inside {OP_MOV, OP_ADD, OP_SUB, OP_AND, OP_XOR};
   wire        take_jmp = cmd_r.op == OP_JMP || (cmd_r.op == OP_JNE && !zero_f) ||
                          (cmd_r.op == OP_JEQ && zero_f);
   wire [15:0] sp_dec   = regs_r[REG_SP] - WORD_STEP;
   // Operand address; autoincrement has already stepped the register
   wire [15:0] src_adr  = (cmd_r.smode == SM_INC) ? src_reg - step : src_reg;
   wire        is_push  = cmd_r.op inside {OP_CALL, OP_IRQ};
   wire        is_pop   = cmd_r.op == OP_INTERRUPT_RETURN;
   wire        irq_take = irq_i & (sw[SW_GIE] | core_off) & ~busy_r & ~bus_req;

   // -----------------------------------------------------------------
   // Memory bus drive
   // -----------------------------------------------------------------
   assign mem_adr_o  = ptr_r;
   assign mem_wdat_o = save_r;
   assign mem_we_o   = state_r == ST_PUSH;
   // Operand read sits in EXEC, once ptr_r holds the operand address
   assign mem_re_o   = state_r == ST_POP || (state_r == ST_EXEC && need_mem);

   // -----------------------------------------------------------------
   // Sequencer: fetch then execute for every source mode, one more cycle for a stack push or pop
   // -----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
         busy_r  <= 1'b0;
         ptr_r   <= 16'h0000;
         save_r  <= 16'h0000;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (irq_take) begin
                  state_r <= ST_PUSH;
                  busy_r  <= 1'b1;
                  ptr_r   <= sp_dec;
                  save_r  <= regs_r[REG_SW] & SW_IMPL_MASK;
               end else if (start_cmd) begin
                  state_r <= ST_FETCH;
                  busy_r  <= 1'b1;
               end
            end
            ST_FETCH: begin
               ptr_r  <= is_pop ? regs_r[REG_SP] : ((need_mem && !is_push) ? src_reg : sp_dec);
               save_r <= regs_r[REG_PC];
               if (is_push) begin
                  state_r <= ST_PUSH;
               end else if (is_pop) begin
                  state_r <= ST_POP;
               end else begin
                  state_r <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_r <= ST_IDLE;
               busy_r  <= 1'b0;
            end
            ST_PUSH: begin
               state_r <= ST_EXEC;
               ptr_r   <= need_mem ? src_adr : ptr_r - WORD_STEP;
               save_r  <= regs_r[REG_PC];
            end
            ST_POP: begin
               state_r <= ST_EXEC;
            end
            default: begin
               state_r <= ST_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Register file writes
   // -----------------------------------------------------------------
   // Interrupt entry stacks only the status word and clears core off,
   // so the handler runs awake; return pops that one word back
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= 16'h0000;
         end
      end else if (state_r == ST_IDLE && bus_wr && (hit_sw || hit_reg)) begin
         if (hit_sw) begin
            regs_r[REG_SW] <= wdat16 & SW_IMPL_MASK;
         end else if (reg_idx != REG_CG) begin
            regs_r[reg_idx] <= wdat16;
         end
      end else if (state_r == ST_FETCH && cmd_r.smode == SM_INC) begin
         regs_r[cmd_r.src] <= src_reg + step;
      end else if (state_r == ST_PUSH) begin
         regs_r[REG_SP] <= ptr_r;
      end else if (state_r == ST_POP) begin
         regs_r[REG_SW] <= mem_rdat_i & SW_IMPL_MASK;
         regs_r[REG_SP] <= regs_r[REG_SP] + WORD_STEP;
      end else if (state_r == ST_EXEC) begin
         if (cmd_r.op == OP_IRQ) begin
            regs_r[REG_PC] <= irq_vector_i;
         end else if (is_dual) begin
            if (cmd_r.dst != REG_CG) begin
               regs_r[cmd_r.dst] <= res;
            end
            if (cmd_r.dst != REG_SW && cmd_r.op != OP_MOV) begin
               regs_r[REG_SW][SW_Z] <= res_zero;
               regs_r[REG_SW][SW_N] <= res_neg;
               regs_r[REG_SW][SW_C] <= res_cry;
            end
         end else if (cmd_r.op inside {OP_CALL, OP_BR}) begin
            regs_r[REG_PC] <= src_val;
         end else if (take_jmp) begin
            regs_r[REG_PC] <= regs_r[REG_PC] + operand_r;
         end
      end else if (state_r == ST_IDLE && irq_take) begin
         regs_r[REG_SW][SW_CORE_CLOCK_OFF] <= 1'b0;
      end
   end

   // Interrupt entry uses the command slot as an internal IRQ op
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cmd_r     <= '0;
         operand_r <= 16'h0000;
         cfg_r     <= 2'b00;
      end else if (state_r == ST_IDLE && irq_take) begin
         cmd_r     <= cpulp_cmd_t'({11'h000, OP_IRQ});  // Register mode: no stray read
      end else if (state_r == ST_IDLE && bus_wr) begin
         if (hit_cmd && !busy_r) cmd_r <= cpulp_cmd_t'(wdat16[14:0]);
         if (hit_opd) operand_r <= wdat16;
         if (hit_cfg) cfg_r <= wdat16[1:0];
      end
   end

   // -----------------------------------------------------------------
   // Wishbone answer: one wait state, unmapped reads return zero
   // -----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r  <= bus_req;
         rdat_r <= hit_sw  ? {16'h0000, sw} :
                   hit_cfg ? {30'h0, cfg_r} :
                   hit_cmd ? {15'h0, busy_r, 1'b0, cmd_r} :
                   hit_opd ? {16'h0000, regs_r[cmd_r.dst]} :
                   hit_cst ? {27'h0, clk_n} :
                   hit_reg ? {16'h0000, regs_r[reg_idx]} : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

endmodule : cpulp_core

`default_nettype wire

// ### core/cpulp_pkg.sv
// Package for the core low-power control block: status word layout, bus map, types
package cpulp_pkg;

   // -----------------------------------------------------------------
   // Status word fields
   // -----------------------------------------------------------------
   localparam int SW_C       = 0;
   localparam int SW_Z       = 1;
   localparam int SW_N       = 2;
   localparam int SW_GIE     = 3;
   localparam int SW_CORE_CLOCK_OFF  = 4;
   localparam int SW_LOW_FREQ_OSC_OFF  = 5;
   localparam int SW_DCGOFF  = 6;
   localparam int SW_SUBOFF  = 7;
   localparam int SW_V       = 8;
   localparam logic [15:0] SW_IMPL_MASK = 16'h01ff;
   localparam logic [15:0] SW_RESET     = 16'h0000;

   // -----------------------------------------------------------------
   // Register numbers
   // -----------------------------------------------------------------
   localparam int NUM_REGS = 16;
   localparam logic [3:0] REG_PC = 4'h0;
   localparam logic [3:0] REG_SP = 4'h1;
   localparam logic [3:0] REG_SW = 4'h2;
   localparam logic [3:0] REG_CG = 4'h3;

   // -----------------------------------------------------------------
   // Wishbone register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADR_STATUS  = 8'h00;  // status word
   localparam logic [7:0] ADR_CLKCFG  = 8'h04;  // source choice bits
   localparam logic [7:0] ADR_CMD     = 8'h08;  // operation command
   localparam logic [7:0] ADR_OPERAND = 8'h0c;  // operand / result
   localparam logic [7:0] ADR_CLKSTAT = 8'h10;  // live clock enables
   localparam logic [7:0] ADR_REGBASE = 8'h40;  // register file window
   localparam logic [7:0] ADR_REGTOP  = 8'h7c;

   // Clock config fields
   localparam int CFG_MAIN_SRC1 = 0;  // main_source_choice bit 1
   localparam int CFG_SUB_SRC   = 1;  // sub_source_choice

   // Command word fields: [3:0] op, [7:4] src reg, [11:8] dst reg,
   // [12] byte variant, [14:13] source mode
   localparam int CMD_BYTE = 12;

   // -----------------------------------------------------------------
   // Operations and source modes
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_MOV   = 4'h0,
      OP_ADD   = 4'h1,
      OP_SUB   = 4'h2,
      OP_AND   = 4'h3,
      OP_XOR   = 4'h4,
      OP_CALL  = 4'h5,
      OP_BR    = 4'h6,
      OP_JMP   = 4'h7,
      OP_JNE   = 4'h8,
      OP_JEQ   = 4'h9,
      OP_IRQ   = 4'ha,
      OP_INTERRUPT_RETURN  = 4'hb
   } cpulp_op_t;

   typedef enum logic [1:0] {
      SM_REG  = 2'h0,
      SM_IND  = 2'h1,
      SM_INC  = 2'h2,
      SM_IMM  = 2'h3
   } cpulp_smode_t;

   typedef struct packed {
      cpulp_smode_t smode;
      logic         byte_op;
      logic [3:0]   dst;
      logic [3:0]   src;
      cpulp_op_t    op;
   } cpulp_cmd_t;

   typedef struct packed {
      logic main_clk_en;
      logic sub_clk_en;
      logic dco_clk_en;
      logic dc_gen_en;
      logic xtal_en;
   } cpulp_clk_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FETCH = 3'b001,
      ST_EXEC  = 3'b011,
      ST_PUSH  = 3'b010,
      ST_POP   = 3'b110
   } cpulp_state_t;

   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;

endpackage : cpulp_pkg

// ### dv/cpulp_periph_model.sv
// Peripheral memory standing on the core's address, data and control buses
`timescale 1ns/100ps
`default_nettype none
module cpulp_periph_model (
   // Clock
   input  wire logic        clock_i,
   // Core side bus
   input  wire logic [15:0] mem_adr_i,
   input  wire logic [15:0] mem_wdat_i,
   input  wire logic        mem_we_i,
   input  wire logic        mem_re_i,
   output logic [15:0]      mem_rdat_o
);
   logic [15:0] mem [0:255];
   logic [15:0] last_r;
   // Known pattern so reads can be predicted by the bench
   initial begin
      last_r = 16'h0000;
      for (int i = 0; i < 256; i++) mem[i] = 16'ha500 ^ 16'(i);
   end
   // Writes land on the edge, like any memory-mapped peripheral
   always @(posedge clock_i) begin
      if (mem_we_i) mem[mem_adr_i[8:1]] <= mem_wdat_i;
      if (mem_re_i) last_r <= mem_rdat_o;
   end
   // Unselected bus shows the inverse of the last word, so stale reads show
   assign mem_rdat_o = mem_re_i ? mem[mem_adr_i[8:1]] : ~last_r;
endmodule : cpulp_periph_model
`default_nettype wire

// ### dv/cpulp_core_checker.sv
// Port assertions for the core, bound to every instance
`timescale 1ns/100ps
`default_nettype none
module cpulp_core_checker
   import cpulp_pkg::*;
#(parameter bit KEEP_XTAL = 1'b0)
(
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        resetn_i,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Interrupt and clock controls
   input wire logic        irq_i,
   input wire logic        main_clk_en_o,
   input wire logic        sub_clk_en_o,
   input wire logic        dco_clk_en_o,
   input wire logic        dc_gen_en_o,
   input wire logic        xtal_en_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // Shadow of the source choice bits; only the bus changes them
   logic [1:0] cfg_r;
   logic       rd_st_r;
   wire logic take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic main_dco_w = main_clk_en_o && !cfg_r[0];
   wire logic sub_dco_w = sub_clk_en_o && !cfg_r[1];
   wire logic xtal_use_w = (main_clk_en_o && cfg_r[0]) || (sub_clk_en_o && cfg_r[1]);
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cfg_r <= 2'h0;
         rd_st_r <= 1'b0;
      end else begin
         if (take_w && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CLKCFG) cfg_r <= wb_dat_i[1:0];
         rd_st_r <= take_w && !wb_we_i && wb_adr_i == ADR_STATUS;
      end
   end
   a_ack_answer: assert property (take_w |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");
   a_reserved_zero: assert property (wb_ack_o && rd_st_r |-> wb_dat_o[31:9] == 23'h0)
      else $error("reserved status bits read nonzero");
   a_reset_clocks: assert property ($rose(resetn_i) |-> main_clk_en_o && sub_clk_en_o
      && dco_clk_en_o && dc_gen_en_o && xtal_en_o)
      else $error("clock enables not all on after reset");
   a_dco_main: assert property (main_dco_w |-> dco_clk_en_o)
      else $error("digital osc stopped while feeding main clock");
   a_dco_sub: assert property (sub_dco_w |-> dco_clk_en_o)
      else $error("digital osc stopped while feeding sub clock");
   a_dco_unused: assert property (!main_dco_w && !sub_dco_w |-> !dco_clk_en_o)
      else $error("digital osc running while unused");
   a_dcgen_used: assert property (!dc_gen_en_o |-> !main_dco_w && !sub_dco_w)
      else $error("dc generator off while digital osc in use");
   a_xtal_kept: assert property (KEEP_XTAL |-> xtal_en_o)
      else $error("crystal stopped despite mask option");
   a_xtal_used: assert property (xtal_use_w |-> xtal_en_o)
      else $error("crystal stopped while feeding a clock");
   a_irq_wake: assert property (irq_i && !main_clk_en_o && !wb_cyc_i |-> ##[1:8] main_clk_en_o)
      else $error("interrupt did not restart main clock");
endmodule : cpulp_core_checker
bind cpulp_core cpulp_core_checker #(.KEEP_XTAL(KEEP_XTAL)) u_chk (.clock_i(clock_i),
   .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq_i(irq_i), .main_clk_en_o(main_clk_en_o),
   .sub_clk_en_o(sub_clk_en_o), .dco_clk_en_o(dco_clk_en_o), .dc_gen_en_o(dc_gen_en_o),
   .xtal_en_o(xtal_en_o));
`default_nettype wire

// ### dv/test_cpu_core_lowpower_control.sv
// Self-checking bench for the core low-power control block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) \
   begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %s expected %h got %h", nm, exp, got); end end
module test_cpu_core_lowpower_control;
   import cpulp_pkg::*;
   typedef struct packed {logic [1:0] cfg; logic [15:0] sw; logic [4:0] en;} cpulp_prow_t;
   typedef struct packed {logic [15:0] c, a, b, r;} cpulp_arow_t;
   // Power rows: source choice, status write, {main,sub,dco,dcgen,xtal}
   localparam cpulp_prow_t PROWS [10] = '{'{2'h0, 16'h0010, 5'h0f}, '{2'h0, 16'h0080, 5'h17},
      '{2'h0, 16'h0090, 5'h03}, '{2'h0, 16'h00f0, 5'h00}, '{2'h0, 16'h0040, 5'h1f},
      '{2'h1, 16'h00c0, 5'h11}, '{2'h2, 16'h0050, 5'h09}, '{2'h2, 16'h0040, 5'h1f},
      '{2'h0, 16'hffff, 5'h00}, '{2'h3, 16'h0060, 5'h19}};
   // Operation rows: command, r4, r5, expected r5
   localparam cpulp_arow_t AROWS [7] = '{'{16'h0541, 16'h0005, 16'h0007, 16'h000c},
      '{16'h1541, 16'h00ff, 16'h0001, 16'h0000}, '{16'h0542, 16'h0003, 16'h000a, 16'h0007},
      '{16'h0543, 16'h0ff0, 16'h3c3c, 16'h0c30}, '{16'h0544, 16'h00ff, 16'h0f0f, 16'h0ff0},
      '{16'h0540, 16'h1234, 16'h5555, 16'h1234}, '{16'h6541, 16'h0005, 16'h0007, 16'h0028}};
   logic        clock_i, resetn_i, cyc, stb, we, irq, ack, mem_we, mem_re, xtal2;
   logic        main_en, sub_en, dco_en, dcg_en, xtal_en, aux_en;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, rw;
   logic [15:0] irq_vec, mem_adr, mem_wdat, mem_rdat;
   int          err_count, total_checks;
   wire logic [4:0] en_w = {main_en, sub_en, dco_en, dcg_en, xtal_en};
   cpulp_core dut (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .mem_adr_o(mem_adr), .mem_wdat_o(mem_wdat), .mem_we_o(mem_we),
      .mem_re_o(mem_re), .mem_rdat_i(mem_rdat), .irq_i(irq), .irq_vector_i(irq_vec),
      .aux_clk_en_o(aux_en), .main_clk_en_o(main_en), .sub_clk_en_o(sub_en),
      .dco_clk_en_o(dco_en), .dc_gen_en_o(dcg_en), .xtal_en_o(xtal_en));
   // Twin with the crystal mask option; sees the same register traffic
   cpulp_core #(.KEEP_XTAL(1'b1)) dut_keep (.clock_i(clock_i), .resetn_i(resetn_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(), .mem_adr_o(), .mem_wdat_o(), .mem_we_o(),
      .mem_re_o(), .mem_rdat_i(mem_rdat), .irq_i(irq), .irq_vector_i(irq_vec),
      .aux_clk_en_o(), .main_clk_en_o(), .sub_clk_en_o(), .dco_clk_en_o(),
      .dc_gen_en_o(), .xtal_en_o(xtal2));
   cpulp_periph_model mdl (.clock_i(clock_i), .mem_adr_i(mem_adr), .mem_wdat_i(mem_wdat),
      .mem_we_i(mem_we), .mem_re_i(mem_re), .mem_rdat_o(mem_rdat));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   // -----------------------------------------------------------------
   // Bus tasks
   // -----------------------------------------------------------------
   // One classic cycle; request held until the edge that samples ack high
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      n = 0;
      do begin @(posedge clock_i); n++; end while (ack !== 1'b1 && n < 20);
      rw = rdat;
      if (ack !== 1'b1) begin err_count++; $display("ERROR wb_ack expected 1 got %b", ack); end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic reg_wr(input logic [3:0] n, input logic [15:0] v);
      wb(1'b1, ADR_REGBASE + {2'b00, n, 2'b00}, v);
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] n);
      wb(1'b0, ADR_REGBASE + {2'b00, n, 2'b00}, 16'h0000);
   endtask : reg_rd
   // Issue a command, then poll busy under a bound
   task automatic cmd(input logic [15:0] c);
      wb(1'b1, ADR_CMD, c);
      wb(1'b0, ADR_CMD, 16'h0000);
      for (int k = 0; k < 20 && rw[16] !== 1'b0; k++) wb(1'b0, ADR_CMD, 16'h0000);
      `CHECK("cmd_done", 1'b0, rw[16])
   endtask : cmd
   task automatic summarize();
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   initial begin
      #(50 * 8000);
      err_count++;
      summarize();
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      int n;
      {resetn_i, cyc, stb, we, irq, adr, wdat} = '0;
      sel = 4'hf;
      irq_vec = 16'h0400;
      err_count = 0;
      total_checks = 0;
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(negedge clock_i);
      `CHECK("clk_en_reset", 5'h1f, en_w)
      wb(1'b0, ADR_STATUS, 16'h0000);
      `CHECK("status_reset", 16'h0000, rw[15:0])
      foreach (PROWS[i]) begin
         wb(1'b1, ADR_CLKCFG, {14'h0000, PROWS[i].cfg});
         wb(1'b1, ADR_STATUS, PROWS[i].sw);
         `CHECK("clk_en", PROWS[i].en, en_w)
         `CHECK("xtal_kept", 1'b1, xtal2)
         `CHECK("aux_clk", PROWS[i].en[0], aux_en)
         wb(1'b0, ADR_STATUS, 16'h0000);
         `CHECK("status_rd", PROWS[i].sw & SW_IMPL_MASK, rw[15:0])
         wb(1'b0, ADR_CLKSTAT, 16'h0000);
         `CHECK("clk_stat", PROWS[i].en, rw[4:0])
      end
      wb(1'b1, ADR_STATUS, 16'h0000);
      wb(1'b1, ADR_CLKCFG, 16'h0000);
      wb(1'b1, ADR_OPERAND, 16'h0021);
      foreach (AROWS[i]) begin
         reg_wr(4'h4, AROWS[i].a);
         reg_wr(4'h5, AROWS[i].b);
         cmd(AROWS[i].c);
         reg_rd(4'h5);
         `CHECK("alu_dst", AROWS[i].r, rw[15:0])
      end
      // Unmapped place and constant register
      wb(1'b1, 8'h30, 16'hffff);
      wb(1'b0, 8'h30, 16'h0000);
      `CHECK("unmapped", 32'h00000000, rw)
      reg_wr(4'h3, 16'h1234);
      reg_rd(4'h3);
      `CHECK("const_reg", 16'h0000, rw[15:0])
      // Autoincrement source read from the peripheral bus
      reg_wr(4'h4, 16'h0010);
      cmd(16'h4540);
      reg_rd(4'h5);
      `CHECK("autoinc_data", 16'ha508, rw[15:0])
      reg_rd(4'h4);
      `CHECK("autoinc_ptr", 16'h0012, rw[15:0])
      // Subroutine call, then computed branch through memory
      reg_wr(4'h1, 16'h0100);
      reg_wr(4'h0, 16'h0030);
      reg_wr(4'h8, 16'h0200);
      cmd(16'h0085);
      reg_rd(4'h0);
      `CHECK("call_pc", 16'h0200, rw[15:0])
      reg_rd(4'h1);
      `CHECK("call_sp", 16'h00fe, rw[15:0])
      `CHECK("call_stack", 16'h0030, mdl.mem[8'h7f])
      reg_wr(4'h4, 16'h0020);
      cmd(16'h2046);
      reg_rd(4'h0);
      `CHECK("br_indirect", 16'ha510, rw[15:0])
      // Jump if unequal with zero set and clear, then unconditional jump, then jump if equal
      for (int j = 0; j < 4; j++) begin
         wb(1'b1, ADR_STATUS, (j != 1) ? 16'h0002 : 16'h0000);
         reg_wr(4'h0, 16'h0100);
         wb(1'b1, ADR_OPERAND, 16'h0010);
         cmd((j == 2) ? 16'h0007 : ((j == 3) ? 16'h0009 : 16'h0008));
         reg_rd(4'h0);
         `CHECK("jump_pc", (j == 0) ? 16'h0100 : 16'h0110, rw[15:0])
      end
      // Interrupt from a low-power mode; handler edits the stacked status
      reg_wr(4'h1, 16'h0200);
      wb(1'b1, ADR_STATUS, 16'h00d0);
      `CHECK("sleep_main", 1'b0, main_en)
      @(posedge clock_i);
      irq <= 1'b1;
      n = 0;
      do begin @(negedge clock_i); n++; end while (main_en !== 1'b1 && n < 20);
      @(posedge clock_i);
      irq <= 1'b0;
      `CHECK("wake_main", 1'b1, main_en)
      reg_rd(4'h0);
      `CHECK("vector_pc", 16'h0400, rw[15:0])
      `CHECK("stacked_status", 16'h00d0, mdl.mem[8'hff])
      mdl.mem[8'hff] = 16'h0080;
      cmd(16'h000b);
      wb(1'b0, ADR_STATUS, 16'h0000);
      `CHECK("interrupt_return_status", 16'h0080, rw[15:0])
      `CHECK("interrupt_return_clocks", 2'b10, {main_en, sub_en})
      summarize();
   end
endmodule : test_cpu_core_lowpower_control
`default_nettype wire
